//--- rtl/arpc_map.vh
// Register map and timing constants for the record path control block
`ifndef ARPC_MAP_VH
`define ARPC_MAP_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ARPC_IDX_POWER_MGMT_TWO 7'h09
`define ARPC_IDX_POWER_MGMT_FOUR 7'h0B
`define ARPC_IDX_CONVERTER_CONTROL 7'h40
`define ARPC_IDX_LEFT_CONVERTER_VOLUME 7'h42
`define ARPC_IDX_RIGHT_CONVERTER_VOLUME 7'h43
`define ARPC_IDX_RIGHT_MIXER_GAIN 7'h63
`define ARPC_IDX_OUTPUT_TO_MIXER_CONTROL 7'h64
`define ARPC_IDX_SAMPLE_RATE 7'h70
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ARPC_BIT_PREAMP_BOOST 0
`define ARPC_LINE_GAIN_HI 7
`define ARPC_LINE_GAIN_LO 5
`define ARPC_AUX_GAIN_HI 15
`define ARPC_AUX_GAIN_LO 13
`define ARPC_BIT_OUT_AMP_SELECT 15
`define ARPC_OUT_AMP_GAIN_HI 3
`define ARPC_OUT_AMP_GAIN_LO 1
`define ARPC_BIT_LEFT_ENABLE 2
`define ARPC_BIT_RIGHT_ENABLE 3
`define ARPC_BIT_VOLUME_ENABLE 15
`define ARPC_BIT_LEFT_INVERT 1
`define ARPC_BIT_RIGHT_INVERT 0
`define ARPC_BIT_RIGHT_MIXER_ENABLE 7
`define ARPC_BIT_LEFT_MIXER_ENABLE 6
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ARPC_GAIN_OFF 3'h0
`define ARPC_RATE_RESET 3'h7
`define ARPC_VOLUME_RESET 15'h00C0
`define ARPC_BOOST_DB 8'h14
`define ARPC_GAIN_BASE_DB 8'hF4
`define ARPC_GAIN_STEP_DB 8'h03
`define ARPC_DB_MUTE 8'h80
`define ARPC_CLK_HZ 125000000
`define ARPC_FIFO_DEPTH 8
`define ARPC_SAMPLE_W 16
`endif

//--- rtl/arpc_fifo.v
// Parameterised valid/ready FIFO for record path samples
`timescale 1ns/1ps
module arpc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

//--- rtl/arpc_top.v
// Record path control registers, polarity and sample stream toward the audio interface
// Overview of operation
// - Right mixer gain bit 0 boosts the right preamp into the right mixer by 20 dB when set.
// - Right mixer gain bits 7:5 set the right line path gain, 000 off, 001 -12 dB up to 111 +6 dB.
// - Right mixer gain bits 15:13 set the right aux path gain with the same coding.
// - Output-to-mixer bit 15 routes the fourth output amp to the left (0) or right (1) mixer.
// - Output-to-mixer bits 3:1 set that amp's gain into the chosen mixer, 000 mutes both.
// - Power management four bits 2 and 3 enable left and right converters, reset disabled.
// - Each enable is one storage bit also seen at bit 15 of its channel volume register.
// - Enables set together start both channels on the same sample slot.
// - Converter control bits 1 and 0 invert left and right sample polarity.
// - Samples pass decimation, volume and high-pass before reaching the audio interface.
// - The record path runs at sample rates from 8 kHz to 48 kHz.
// - Power management two bits 7 and 6 enable right and left record mixers, reset disabled.
`timescale 1ns/1ps
`include "arpc_map.vh"
module arpc_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [8:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire [15:0] left_sample_i,
    input wire [15:0] right_sample_i,
    input wire sample_valid_i,
    output wire sample_ready_o,
    output wire [31:0] stream_data_o,
    output wire stream_valid_o,
    input wire stream_ready_i,
    output reg right_preamp_db_o,
    output reg [7:0] right_line_path_gain_db_o,
    output reg [7:0] right_aux_path_gain_db_o,
    output reg [7:0] left_out_amp_gain_db_o,
    output reg [7:0] right_out_amp_gain_db_o,
    output reg left_converter_enable_o,
    output reg right_converter_enable_o,
    output reg left_mixer_enable_o,
    output reg right_mixer_enable_o,
    output reg [2:0] sample_rate_sel_o
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg right_preamp_boost_q;
    reg [2:0] right_line_path_gain_q;
    reg [2:0] right_aux_path_gain_q;
    reg out_amp_mixer_select_q;
    reg [2:0] out_amp_mixer_gain_q;

    reg left_converter_enable_q;
    reg right_converter_enable_q;

    reg left_polarity_invert_q;
    reg right_polarity_invert_q;
    reg left_mixer_enable_q;
    reg right_mixer_enable_q;
    reg [2:0] sample_rate_q;

    reg [15:0] power_two_rest_q;
    reg [15:0] power_four_rest_q;
    reg [15:0] control_rest_q;
    reg [14:0] left_volume_rest_q;
    reg [14:0] right_volume_rest_q;
    reg [15:0] mixer_gain_rest_q;
    reg [15:0] out_mixer_rest_q;

    reg left_run_q;
    reg right_run_q;

    wire [6:0] idx;
    wire req;
    wire wr;
    wire [15:0] wd;

    reg hit;
    reg [15:0] rd;

    assign idx = wb_adr_i[8:2];
    // An answer in flight blocks a second take of the same request
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = req && wb_we_i && hit;

    // Byte lanes 0 and 1 carry the 16-bit register
    assign wd = {wb_sel_i[1] ? wb_dat_i[15:8] : rd[15:8],
        wb_sel_i[0] ? wb_dat_i[7:0] : rd[7:0]};

    // ----------------------------------------
    // Gain decode
    // ----------------------------------------
    function [7:0] arpc_gain_db;
        input [2:0] code;
        reg [7:0] steps;
        begin
            // Codes between the end points are spaced evenly
            steps = {5'h00, code - 3'h1};
            if (code == `ARPC_GAIN_OFF)
            begin
                arpc_gain_db = `ARPC_DB_MUTE;
            end
            else
            begin
                arpc_gain_db = `ARPC_GAIN_BASE_DB + steps * `ARPC_GAIN_STEP_DB;
            end
        end
    endfunction

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @*
    begin
        hit = 1'b1;
        rd = 16'h0000;
        case (idx)
            `ARPC_IDX_POWER_MGMT_TWO:
            begin
                rd = power_two_rest_q;
                rd[`ARPC_BIT_RIGHT_MIXER_ENABLE] = right_mixer_enable_q;
                rd[`ARPC_BIT_LEFT_MIXER_ENABLE] = left_mixer_enable_q;
            end

            `ARPC_IDX_POWER_MGMT_FOUR:
            begin
                rd = power_four_rest_q;
                rd[`ARPC_BIT_LEFT_ENABLE] = left_converter_enable_q;
                rd[`ARPC_BIT_RIGHT_ENABLE] = right_converter_enable_q;
            end

            `ARPC_IDX_CONVERTER_CONTROL:
            begin
                rd = control_rest_q;
                rd[`ARPC_BIT_LEFT_INVERT] = left_polarity_invert_q;
                rd[`ARPC_BIT_RIGHT_INVERT] = right_polarity_invert_q;
            end

            `ARPC_IDX_LEFT_CONVERTER_VOLUME:
            begin
                rd = {left_converter_enable_q, left_volume_rest_q};
            end

            `ARPC_IDX_RIGHT_CONVERTER_VOLUME:
            begin
                rd = {right_converter_enable_q, right_volume_rest_q};
            end

            `ARPC_IDX_RIGHT_MIXER_GAIN:
            begin
                rd = mixer_gain_rest_q;
                rd[`ARPC_BIT_PREAMP_BOOST] = right_preamp_boost_q;
                rd[`ARPC_LINE_GAIN_HI:`ARPC_LINE_GAIN_LO] = right_line_path_gain_q;
                rd[`ARPC_AUX_GAIN_HI:`ARPC_AUX_GAIN_LO] = right_aux_path_gain_q;
            end

            `ARPC_IDX_OUTPUT_TO_MIXER_CONTROL:
            begin
                rd = out_mixer_rest_q;
                rd[`ARPC_BIT_OUT_AMP_SELECT] = out_amp_mixer_select_q;
                rd[`ARPC_OUT_AMP_GAIN_HI:`ARPC_OUT_AMP_GAIN_LO] = out_amp_mixer_gain_q;
            end

            `ARPC_IDX_SAMPLE_RATE:
            begin
                rd = {13'h0000, sample_rate_q};
            end

            default:
            begin
                hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Bus slave and register writes
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;

            right_preamp_boost_q <= 1'b0;
            right_line_path_gain_q <= `ARPC_GAIN_OFF;
            right_aux_path_gain_q <= `ARPC_GAIN_OFF;
            out_amp_mixer_select_q <= 1'b0;
            out_amp_mixer_gain_q <= `ARPC_GAIN_OFF;
            left_converter_enable_q <= 1'b0;
            right_converter_enable_q <= 1'b0;
            left_polarity_invert_q <= 1'b0;
            right_polarity_invert_q <= 1'b0;
            left_mixer_enable_q <= 1'b0;
            right_mixer_enable_q <= 1'b0;
            sample_rate_q <= `ARPC_RATE_RESET;

            power_two_rest_q <= 16'h0000;
            power_four_rest_q <= 16'h0000;
            control_rest_q <= 16'h0000;
            left_volume_rest_q <= `ARPC_VOLUME_RESET;
            right_volume_rest_q <= `ARPC_VOLUME_RESET;
            mixer_gain_rest_q <= 16'h0000;
            out_mixer_rest_q <= 16'h0000;
        end
        else
        begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= (req && !wb_we_i && hit) ? {16'h0000, rd} : 32'h00000000;

            if (wr)
            begin
                case (idx)
                    `ARPC_IDX_POWER_MGMT_TWO:
                    begin
                        power_two_rest_q <= wd;
                        right_mixer_enable_q <= wd[`ARPC_BIT_RIGHT_MIXER_ENABLE];
                        left_mixer_enable_q <= wd[`ARPC_BIT_LEFT_MIXER_ENABLE];
                    end

                    `ARPC_IDX_POWER_MGMT_FOUR:
                    begin
                        // Both enables land on the same edge from one write
                        power_four_rest_q <= wd;
                        left_converter_enable_q <= wd[`ARPC_BIT_LEFT_ENABLE];
                        right_converter_enable_q <= wd[`ARPC_BIT_RIGHT_ENABLE];
                    end

                    `ARPC_IDX_CONVERTER_CONTROL:
                    begin
                        control_rest_q <= wd;
                        left_polarity_invert_q <= wd[`ARPC_BIT_LEFT_INVERT];
                        right_polarity_invert_q <= wd[`ARPC_BIT_RIGHT_INVERT];
                    end

                    `ARPC_IDX_LEFT_CONVERTER_VOLUME:
                    begin
                        left_converter_enable_q <= wd[`ARPC_BIT_VOLUME_ENABLE];
                        left_volume_rest_q <= wd[14:0];
                    end

                    `ARPC_IDX_RIGHT_CONVERTER_VOLUME:
                    begin
                        right_converter_enable_q <= wd[`ARPC_BIT_VOLUME_ENABLE];
                        right_volume_rest_q <= wd[14:0];
                    end

                    `ARPC_IDX_RIGHT_MIXER_GAIN:
                    begin
                        mixer_gain_rest_q <= wd;
                        right_preamp_boost_q <= wd[`ARPC_BIT_PREAMP_BOOST];
                        right_line_path_gain_q <= wd[`ARPC_LINE_GAIN_HI:`ARPC_LINE_GAIN_LO];
                        right_aux_path_gain_q <= wd[`ARPC_AUX_GAIN_HI:`ARPC_AUX_GAIN_LO];
                    end

                    `ARPC_IDX_OUTPUT_TO_MIXER_CONTROL:
                    begin
                        out_mixer_rest_q <= wd;
                        out_amp_mixer_select_q <= wd[`ARPC_BIT_OUT_AMP_SELECT];
                        out_amp_mixer_gain_q <= wd[`ARPC_OUT_AMP_GAIN_HI:`ARPC_OUT_AMP_GAIN_LO];
                    end

                    `ARPC_IDX_SAMPLE_RATE:
                    begin
                        sample_rate_q <= wd[2:0];
                    end

                    default:
                    begin
                        sample_rate_q <= sample_rate_q;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Analogue control outputs
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            right_preamp_db_o <= 1'b0;
            right_line_path_gain_db_o <= `ARPC_DB_MUTE;
            right_aux_path_gain_db_o <= `ARPC_DB_MUTE;
            left_out_amp_gain_db_o <= `ARPC_DB_MUTE;
            right_out_amp_gain_db_o <= `ARPC_DB_MUTE;

            left_converter_enable_o <= 1'b0;
            right_converter_enable_o <= 1'b0;
            left_mixer_enable_o <= 1'b0;
            right_mixer_enable_o <= 1'b0;
            sample_rate_sel_o <= `ARPC_RATE_RESET;
        end
        else
        begin
            right_preamp_db_o <= right_preamp_boost_q;
            right_line_path_gain_db_o <= arpc_gain_db(right_line_path_gain_q);
            right_aux_path_gain_db_o <= arpc_gain_db(right_aux_path_gain_q);

            // Only one mixer takes the amp; the other sees mute
            left_out_amp_gain_db_o <= out_amp_mixer_select_q ? `ARPC_DB_MUTE :
                arpc_gain_db(out_amp_mixer_gain_q);
            right_out_amp_gain_db_o <= out_amp_mixer_select_q ?
                arpc_gain_db(out_amp_mixer_gain_q) : `ARPC_DB_MUTE;

            left_converter_enable_o <= left_converter_enable_q;
            right_converter_enable_o <= right_converter_enable_q;
            left_mixer_enable_o <= left_mixer_enable_q;
            right_mixer_enable_o <= right_mixer_enable_q;
            sample_rate_sel_o <= sample_rate_q;
        end
    end

    // ----------------------------------------
    // Sample path
    // ----------------------------------------
    // Channels start only at a sample boundary, so a joint enable aligns both
    wire fifo_ready;
    wire [15:0] left_out;
    wire [15:0] right_out;
    wire take;

    assign take = sample_valid_i && fifo_ready;
    assign sample_ready_o = fifo_ready;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            left_run_q <= 1'b0;
            right_run_q <= 1'b0;
        end
        else if (take)
        begin
            left_run_q <= left_converter_enable_q;
            right_run_q <= right_converter_enable_q;
        end
    end

    // Inputs are decimated, volume-scaled and filtered upstream
    assign left_out = left_run_q ? (left_polarity_invert_q ?
        16'h0000 - left_sample_i : left_sample_i) : 16'h0000;

    assign right_out = right_run_q ? (right_polarity_invert_q ?
        16'h0000 - right_sample_i : right_sample_i) : 16'h0000;

    arpc_fifo #(
        .WIDTH(32),
        .DEPTH(`ARPC_FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i({left_out, right_out}),
        .in_valid_i(sample_valid_i && (left_run_q || right_run_q)),
        .in_ready_o(fifo_ready),
        .out_data_o(stream_data_o),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i)
    );
endmodule

//--- verification/arpc_top_assertions.sv
// Port-level assertions for the record path control block
`timescale 1ns/1ps
`include "arpc_map.vh"
module arpc_top_assertions (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [8:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire sample_ready_o,
    input wire [31:0] stream_data_o,
    input wire stream_valid_o,
    input wire stream_ready_i,
    input wire right_preamp_db_o,
    input wire [7:0] right_line_path_gain_db_o,
    input wire [7:0] right_aux_path_gain_db_o,
    input wire [7:0] left_out_amp_gain_db_o,
    input wire [7:0] right_out_amp_gain_db_o,
    input wire left_converter_enable_o,
    input wire right_converter_enable_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire [6:0] idx = wb_adr_i[8:2];
    wire wr = take && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
    wire mapped = idx == `ARPC_IDX_POWER_MGMT_TWO || idx == `ARPC_IDX_POWER_MGMT_FOUR
        || idx == `ARPC_IDX_CONVERTER_CONTROL || idx == `ARPC_IDX_LEFT_CONVERTER_VOLUME
        || idx == `ARPC_IDX_RIGHT_CONVERTER_VOLUME || idx == `ARPC_IDX_RIGHT_MIXER_GAIN
        || idx == `ARPC_IDX_OUTPUT_TO_MIXER_CONTROL || idx == `ARPC_IDX_SAMPLE_RATE;
    function automatic [7:0] gdb(input [2:0] c);
        gdb = (c == 3'h0) ? 8'h80 : 8'hF4 + 8'h03 * {5'h00, c - 3'h1};
    endfunction
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_mix;
        wr && idx == `ARPC_IDX_RIGHT_MIXER_GAIN |-> ##2
            (right_line_path_gain_db_o == gdb($past(wb_dat_i[7:5], 2))
            && right_aux_path_gain_db_o == gdb($past(wb_dat_i[15:13], 2)));
    endproperty
    property p_route;
        wr && idx == `ARPC_IDX_OUTPUT_TO_MIXER_CONTROL |-> ##2
            ({left_out_amp_gain_db_o, right_out_amp_gain_db_o} == ($past(wb_dat_i[15], 2) ?
            {8'h80, gdb($past(wb_dat_i[3:1], 2))} : {gdb($past(wb_dat_i[3:1], 2)), 8'h80}));
    endproperty
    a_bus_answer: assert property (take |=> (wb_ack_o ^ wb_err_o))
        else $error("bus answer missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
        else $error("ack longer than one cycle");
    a_unmapped_err: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_read_data_idle: assert property (wb_dat_o[31:16] == 16'h0000 && (wb_ack_o || wb_dat_o == 32'h0))
        else $error("read data outside ack");
    a_mixer_gain: assert property (p_mix)
        else $error("mixer gain decode wrong");
    a_preamp_boost: assert property (wr && idx == `ARPC_IDX_RIGHT_MIXER_GAIN |-> ##2
        right_preamp_db_o == $past(wb_dat_i[0], 2)) else $error("boost wrong");
    a_out_route: assert property (p_route)
        else $error("out amp routing wrong");
    a_pair_enable: assert property (wr && idx == `ARPC_IDX_POWER_MGMT_FOUR |-> ##2
        {left_converter_enable_o, right_converter_enable_o} == {$past(wb_dat_i[2], 2),
        $past(wb_dat_i[3], 2)}
        ) else $error("enables not set together");
    a_left_mirror: assert property (wr && idx == `ARPC_IDX_LEFT_CONVERTER_VOLUME |-> ##2
        left_converter_enable_o == $past(wb_dat_i[15], 2)) else $error("left mirror wrong");
    a_reset_state: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
        (!wb_ack_o && !left_converter_enable_o && !right_converter_enable_o && !stream_valid_o
        && right_line_path_gain_db_o == 8'h80)) else $error("reset state wrong");
    a_stream_hold: assert property (stream_valid_o && !stream_ready_i |=>
        stream_valid_o && $stable(stream_data_o)) else $error("stream word not held");
    c_err: cover property (wb_err_o);
    c_full: cover property (stream_valid_o && !sample_ready_o);
    c_pair: cover property ($rose(left_converter_enable_o) && $rose(right_converter_enable_o));
endmodule
bind arpc_top arpc_top_assertions i_arpc_top_assertions (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .sample_ready_o,
    .stream_data_o, .stream_valid_o, .stream_ready_i, .right_preamp_db_o,
    .right_line_path_gain_db_o, .right_aux_path_gain_db_o, .left_out_amp_gain_db_o,
    .right_out_amp_gain_db_o, .left_converter_enable_o, .right_converter_enable_o);

//--- verification/arpc_top_bench.sv
// Self-checking bench for the record path control block
`timescale 1ns/1ps
`include "arpc_map.vh"
module arpc_top_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [8:0] wb_adr_i = 9'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [15:0] left_sample_i = 16'h0000, right_sample_i = 16'h0000;
    logic sample_valid_i = 1'b0, stream_ready_i = 1'b0;
    wire [31:0] wb_dat_o, stream_data_o;
    wire wb_ack_o, wb_err_o, sample_ready_o, stream_valid_o, boost;
    wire [7:0] line_db, aux_db, lout_db, rout_db;
    wire left_en, right_en, lmix_en, rmix_en;
    wire [2:0] rate_sel;
    int miscompares = 0;
    int check_count = 0;
    logic [15:0] rd, v;
    logic er;
    logic [1:0] pol;
    logic [31:0] expq[$];
    arpc_top i_arpc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .left_sample_i(left_sample_i), .right_sample_i(right_sample_i),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .stream_data_o(stream_data_o), .stream_valid_o(stream_valid_o),
        .stream_ready_i(stream_ready_i), .right_preamp_db_o(boost),
        .right_line_path_gain_db_o(line_db), .right_aux_path_gain_db_o(aux_db),
        .left_out_amp_gain_db_o(lout_db), .right_out_amp_gain_db_o(rout_db),
        .left_converter_enable_o(left_en), .right_converter_enable_o(right_en),
        .left_mixer_enable_o(lmix_en), .right_mixer_enable_o(rmix_en),
        .sample_rate_sel_o(rate_sel));
    // ----------------------------------------
    // Expectations and bus access
    // ----------------------------------------
    function automatic [7:0] gain_db(input [2:0] c);
        gain_db = (c == 3'h0) ? 8'h80 : 8'hF4 + {5'h00, c - 3'h1} * 8'h03;
    endfunction
    function automatic [31:0] exp_word(input [1:0] inv, input [15:0] l, input [15:0] r);
        exp_word = {inv[1] ? 16'h0000 - l : l, inv[0] ? 16'h0000 - r : r};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic we, input logic [6:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, wd};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("bus answer", 1, n < 40);
        rd = wb_dat_o[15:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h5CD2));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("gains reset", 32'h80808080, {lout_db, rout_db, line_db, aux_db});
        chk("enables reset", 0, {left_en, right_en, lmix_en, rmix_en});
        chk("rate reset", 7, rate_sel);
        bus(1'b0, `ARPC_IDX_LEFT_CONVERTER_VOLUME, 16'h0000);
        chk("volume reset", 32'h0C0, {rd[15], rd[7:0]});
        bus(1'b1, 7'h10, 16'h1234);
        chk("unmapped err", 1, er);
        bus(1'b1, `ARPC_IDX_SAMPLE_RATE, 16'h0003);
        chk("rate select", 3, rate_sel);
        for (int i = 0; i < 16; i++)
        begin
            v = 16'($urandom);
            v[7:5] = i[2:0];
            bus(1'b1, `ARPC_IDX_RIGHT_MIXER_GAIN, v);
            bus(1'b0, `ARPC_IDX_RIGHT_MIXER_GAIN, 16'h0000);
            chk("mixer readback", v, rd);
            chk("line gain", gain_db(i[2:0]), line_db);
            chk("aux gain", gain_db(v[15:13]), aux_db);
            chk("preamp boost", v[0], boost);
            v = 16'($urandom);
            v[15] = i[3];
            v[3:1] = i[2:0];
            bus(1'b1, `ARPC_IDX_OUTPUT_TO_MIXER_CONTROL, v);
            repeat (2) @(posedge clk_i);
            chk("out amp gains", i[3] ? {8'h80, gain_db(i[2:0])} : {gain_db(i[2:0]), 8'h80},
                {lout_db, rout_db});
        end
        bus(1'b1, `ARPC_IDX_POWER_MGMT_FOUR, 16'h0004);
        bus(1'b0, `ARPC_IDX_LEFT_CONVERTER_VOLUME, 16'h0000);
        chk("left mirror", 1, rd[15]);
        bus(1'b0, `ARPC_IDX_RIGHT_CONVERTER_VOLUME, 16'h0000);
        chk("right mirror", 0, rd[15]);
        bus(1'b1, `ARPC_IDX_RIGHT_CONVERTER_VOLUME, 16'h80C0);
        bus(1'b0, `ARPC_IDX_POWER_MGMT_FOUR, 16'h0000);
        chk("pm four enables", 3, rd[3:2]);
        chk("enable outputs", 3, {left_en, right_en});
        bus(1'b1, `ARPC_IDX_POWER_MGMT_TWO, 16'h0080);
        repeat (2) @(posedge clk_i);
        chk("mixer enables", 1, {lmix_en, rmix_en});
        bus(1'b1, `ARPC_IDX_POWER_MGMT_FOUR, 16'h0000);
        for (int p = 1; p < 3; p++)
        begin
            pol = p[1:0];
            bus(1'b1, `ARPC_IDX_CONVERTER_CONTROL, {14'h0000, pol});
            bus(1'b1, `ARPC_IDX_POWER_MGMT_FOUR, 16'h000C);
            // First sample after enabling may be dropped, so flush it
            sample_valid_i <= 1'b1;
            @(posedge clk_i);
            sample_valid_i <= 1'b0;
            stream_ready_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            stream_ready_i <= 1'b0;
            left_sample_i <= (p == 2) ? 16'h8000 : 16'($urandom);
            right_sample_i <= 16'($urandom);
            sample_valid_i <= 1'b1;
            repeat (10)
            begin
                @(posedge clk_i);
                if (sample_ready_o === 1'b1)
                begin
                    expq.push_back(exp_word(pol, left_sample_i, right_sample_i));
                    left_sample_i <= 16'($urandom);
                    right_sample_i <= 16'($urandom);
                end
            end
            sample_valid_i <= 1'b0;
            chk("fifo fill count", 8, expq.size());
            chk("ready when full", 0, sample_ready_o);
            stream_ready_i <= 1'b1;
            repeat (12)
            begin
                @(posedge clk_i);
                if (stream_valid_o === 1'b1 && expq.size() > 0)
                    chk("stream word", expq.pop_front(), stream_data_o);
            end
            chk("drained", 0, {expq.size() != 0, stream_valid_o});
            stream_ready_i <= 1'b0;
            bus(1'b1, `ARPC_IDX_POWER_MGMT_FOUR, 16'h0000);
        end
        end_of_test();
    end
endmodule
